// *** rtl/sad_bar_file.sv ***
// sad_bar_file: companion base pointers, writable only until boot is locked
// assumes: the decoder passes the write strobe through and drives lock from its own state
`timescale 1ns/1ns
`default_nettype none
module sad_bar_file
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // pointer bundle
  sad_bar_if.owner  bar
);

  logic [31:0] base_reg  [sad_pkg::NUM_BARS];
  logic [31:0] base_next [sad_pkg::NUM_BARS];

  // ****************************************
  // one pointer per entry
  // ****************************************
  for (genvar g = 0; g < sad_pkg::NUM_BARS; g++)
  begin : g_bar
    // relocation only while boot is open; the rom pointer resets to the trap
    always_comb
    begin
      base_next[g] = base_reg[g];
      if (bar.wr && !bar.lock && bar.sel == 2'(g))
        base_next[g] = bar.wdata; // RULE_07
    end

    always_ff @(posedge clk_i)
    begin
      if (reset_i)
        base_reg[g] <= (g == 0) ? sad_pkg::TRAP_PCI_ADDR : 32'h0000_0000; // RULE_09
      else
        base_reg[g] <= base_next[g];
    end

    assign bar.base[g] = base_reg[g]; // RULE_08
  end

endmodule
`default_nettype wire

// *** rtl/sad_bar_if.sv ***
// sad_bar_if: companion base pointer bundle between decoder and base file
// assumes: one clock domain, pointers held as 32-bit pci addresses
`timescale 1ns/1ns
`default_nettype none
interface sad_bar_if;
  logic        wr;
  logic [1:0]  sel;
  logic [31:0] wdata;
  logic        lock;
  logic [31:0] base [3];

  modport owner (input wr, input sel, input wdata, input lock, output base);
  modport user  (output wr, output sel, output wdata, output lock, input base);
endinterface
`default_nettype wire

// *** rtl/sad_decoder.sv ***
// sad_decoder: routes cpu physical and pci addresses to their ports, and
// decodes companion accesses as offsets from relocatable base pointers
// assumes: addresses and strobes synchronous to clk_i; one decision per cycle
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE_01: memory below 1 GB cacheable; graphics and cpu io windows non-cacheable.
// RULE_02: with bridge fitted, pci space splits between slot and onboard buses.
// RULE_03: pci 0x8000_0000..0xBFFF_FFFF is primary dma space, setting 0x30.
// RULE_04: slot bus owns memory 0x4000_0000..0x7FFF_FFFF, setting 0x0c.
// RULE_05: firmware programs slot addresses; slot io is 0x40_0000..0x7F_FFFF.
// RULE_06: onboard bus owns two memory windows, setting 0xc3, and two io windows.
// RULE_07: companion bases relocatable only during boot; registers decoded as offsets.
// RULE_08: companion exposes rom, expansion bus fn 0 and network fn 1 pointers.
// RULE_09: reset trap at cpu 0x1FF_F000_0000, pci 0xF000_0000, expansion offset 0.
// RULE_10: rom offsets 0x00_0000..0xFF_FFFF, read-only, one or four byte accesses.
// RULE_11: accesses in the unused physical range go to no port.
module sad_decoder
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // cpu request
  input  wire logic        cpu_req_i,
  input  wire logic [40:0] cpu_addr_i,
  // pci request
  input  wire logic        pci_req_i,
  input  wire logic        pci_io_i,
  input  wire logic [31:0] pci_addr_i,
  input  wire logic        pci_write_i,
  input  wire logic [2:0]  pci_size_i,
  // bridge and boot control
  input  wire logic        bridge_fitted_i,
  input  wire logic        boot_done_i,
  input  wire logic        bar_wr_i,
  input  wire logic [1:0]  bar_sel_i,
  input  wire logic [31:0] bar_wdata_i,
  // cpu decision
  output logic             cpu_valid_o,
  output logic [2:0]       cpu_port_o,
  output logic             cpu_cacheable_o,
  output logic             cpu_trap_o,
  // pci decision
  output logic             pci_valid_o,
  output logic [2:0]       pci_port_o,
  output logic [7:0]       pci_setting_o,
  output logic             rom_hit_o,
  output logic             rom_err_o,
  output logic [23:0]      rom_offset_o,
  output logic             exp_hit_o,
  output logic             net_hit_o,
  // status
  output logic             boot_open_o,
  output logic [31:0]      rom_base_o
);

  sad_bar_if bar ();

  // ****************************************
  // boot window state
  // ****************************************
  sad_pkg::sad_state_t state_reg;
  sad_pkg::sad_state_t state_next;

  // relocation closes until the next reset once boot completes
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      sad_pkg::SAD_ST_RESET:  state_next = sad_pkg::SAD_ST_BOOT;
      sad_pkg::SAD_ST_BOOT:   if (boot_done_i) state_next = sad_pkg::SAD_ST_LOCKED; // RULE_07
      sad_pkg::SAD_ST_LOCKED: state_next = sad_pkg::SAD_ST_LOCKED;
      default:                state_next = sad_pkg::SAD_ST_RESET;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      state_reg <= sad_pkg::SAD_ST_RESET;
    else
      state_reg <= state_next;
  end

  // bundle to base file; writes in reset state are ignored too
  assign bar.wr    = bar_wr_i;
  assign bar.sel   = bar_sel_i;
  assign bar.wdata = bar_wdata_i;
  assign bar.lock  = (state_reg != sad_pkg::SAD_ST_BOOT); // RULE_07

  sad_bar_file u_bar
  (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .bar     (bar)
  );

  // ****************************************
  // cpu physical decode
  // ****************************************
  logic       cpu_valid_reg,  cpu_valid_next;
  logic [2:0] cpu_port_reg,   cpu_port_next;
  logic       cpu_cache_reg,  cpu_cache_next;
  logic       cpu_trap_reg,   cpu_trap_next;

  // gaps decode to none so nothing is forwarded
  always_comb
  begin
    cpu_valid_next = cpu_req_i;
    cpu_port_next  = sad_pkg::SAD_CPU_NONE; // RULE_11
    cpu_cache_next = 1'b0;
    cpu_trap_next  = cpu_req_i && (cpu_addr_i == sad_pkg::TRAP_CPU_ADDR); // RULE_09
    if (cpu_addr_i <= sad_pkg::MEM_TOP)
    begin
      cpu_port_next  = sad_pkg::SAD_CPU_MEM; // RULE_01
      cpu_cache_next = 1'b1;
    end
    else if (cpu_addr_i >= sad_pkg::GFX_BASE && cpu_addr_i <= sad_pkg::GFX_TOP)
      cpu_port_next = sad_pkg::SAD_CPU_GFX; // RULE_01
    else if (cpu_addr_i >= sad_pkg::CPUIO_BASE)
      cpu_port_next = sad_pkg::SAD_CPU_IO; // RULE_01
    if (!cpu_req_i)
    begin
      cpu_port_next  = sad_pkg::SAD_CPU_NONE;
      cpu_cache_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cpu_valid_reg <= 1'b0;
      cpu_port_reg  <= sad_pkg::SAD_CPU_NONE;
      cpu_cache_reg <= 1'b0;
      cpu_trap_reg  <= 1'b0;
    end
    else
    begin
      cpu_valid_reg <= cpu_valid_next;
      cpu_port_reg  <= cpu_port_next;
      cpu_cache_reg <= cpu_cache_next;
      cpu_trap_reg  <= cpu_trap_next;
    end
  end

  // ****************************************
  // pci decode
  // ****************************************
  logic        pci_valid_reg, pci_valid_next;
  logic [2:0]  pci_port_reg,  pci_port_next;
  logic [7:0]  pci_set_reg,   pci_set_next;
  logic        rom_hit_reg,   rom_hit_next;
  logic        rom_err_reg,   rom_err_next;
  logic [23:0] rom_off_reg,   rom_off_next;
  logic        exp_hit_reg,   exp_hit_next;
  logic        net_hit_reg,   net_hit_next;
  logic [31:0] rom_rel;
  logic [31:0] exp_rel;
  logic [31:0] net_rel;

  // offsets from the relocatable pointers; unsigned wrap misses below base
  assign rom_rel = pci_addr_i - bar.base[0]; // RULE_07
  assign exp_rel = pci_addr_i - bar.base[1];
  assign net_rel = pci_addr_i - bar.base[2];

  // without the bridge every pci access outside the dma window belongs to the slot bus
  always_comb
  begin
    pci_valid_next = pci_req_i;
    pci_port_next  = sad_pkg::SAD_PCI_NONE;
    pci_set_next   = 8'h00;
    rom_hit_next   = 1'b0;
    rom_err_next   = 1'b0;
    rom_off_next   = 24'h00_0000;
    exp_hit_next   = 1'b0;
    net_hit_next   = 1'b0;
    if (pci_req_i && !pci_io_i)
    begin
      if (pci_addr_i >= sad_pkg::DEV_DMA_BASE && pci_addr_i <= sad_pkg::DEV_DMA_TOP)
      begin
        pci_port_next = sad_pkg::SAD_PCI_DMA; // RULE_03
        pci_set_next  = sad_pkg::DEV_DMA_SETTING;
      end
      else if (!bridge_fitted_i ||
               (pci_addr_i >= sad_pkg::SLOT_MEM_BASE && pci_addr_i <= sad_pkg::SLOT_MEM_TOP))
      begin
        pci_port_next = sad_pkg::SAD_PCI_SLOT; // RULE_04
        pci_set_next  = sad_pkg::SLOT_SETTING;
      end
      else
      begin
        pci_port_next = sad_pkg::SAD_PCI_ONB; // RULE_02 RULE_06
        pci_set_next  = sad_pkg::ONB_SETTING;
      end
      // companion windows decode on every memory access, whichever port it takes
      if (rom_rel <= 32'(sad_pkg::ROM_TOP))
      begin
        rom_hit_next = 1'b1; // RULE_08
        rom_off_next = rom_rel[23:0]; // RULE_10
        rom_err_next = pci_write_i || !(pci_size_i == 3'h1 || pci_size_i == 3'h4); // RULE_10
      end
      exp_hit_next = (exp_rel <= 32'(sad_pkg::ROM_TOP)); // RULE_08
      net_hit_next = (net_rel <= 32'(sad_pkg::ROM_TOP));
    end
    else if (pci_req_i)
    begin
      if (bridge_fitted_i && !(pci_addr_i >= sad_pkg::SLOT_IO_BASE && pci_addr_i <= sad_pkg::SLOT_IO_TOP))
      begin
        if (pci_addr_i <= sad_pkg::ONB_IO_LO_TOP ||
            (pci_addr_i >= sad_pkg::ONB_IO_HI_BASE && pci_addr_i <= sad_pkg::ONB_IO_HI_TOP))
          pci_port_next = sad_pkg::SAD_PCI_ONB; // RULE_06
      end
      else
        pci_port_next = sad_pkg::SAD_PCI_SLOT; // RULE_05
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pci_valid_reg <= 1'b0;
      pci_port_reg  <= sad_pkg::SAD_PCI_NONE;
      pci_set_reg   <= 8'h00;
      rom_hit_reg   <= 1'b0;
      rom_err_reg   <= 1'b0;
      rom_off_reg   <= 24'h00_0000;
      exp_hit_reg   <= 1'b0;
      net_hit_reg   <= 1'b0;
    end
    else
    begin
      pci_valid_reg <= pci_valid_next;
      pci_port_reg  <= pci_port_next;
      pci_set_reg   <= pci_set_next;
      rom_hit_reg   <= rom_hit_next;
      rom_err_reg   <= rom_err_next;
      rom_off_reg   <= rom_off_next;
      exp_hit_reg   <= exp_hit_next;
      net_hit_reg   <= net_hit_next;
    end
  end

  // ****************************************
  // status registers
  // ****************************************
  logic        boot_open_reg;
  logic [31:0] rom_base_reg;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      boot_open_reg <= 1'b0;
      rom_base_reg  <= sad_pkg::TRAP_PCI_ADDR;
    end
    else
    begin
      boot_open_reg <= (state_reg == sad_pkg::SAD_ST_BOOT);
      rom_base_reg  <= bar.base[0];
    end
  end

  // all outputs straight from flip-flops
  assign cpu_valid_o     = cpu_valid_reg;
  assign cpu_port_o      = cpu_port_reg;
  assign cpu_cacheable_o = cpu_cache_reg;
  assign cpu_trap_o      = cpu_trap_reg;
  assign pci_valid_o     = pci_valid_reg;
  assign pci_port_o      = pci_port_reg;
  assign pci_setting_o   = pci_set_reg;
  assign rom_hit_o       = rom_hit_reg;
  assign rom_err_o       = rom_err_reg;
  assign rom_offset_o    = rom_off_reg;
  assign exp_hit_o       = exp_hit_reg;
  assign net_hit_o       = net_hit_reg;
  assign boot_open_o     = boot_open_reg;
  assign rom_base_o      = rom_base_reg;

endmodule
`default_nettype wire

// *** rtl/sad_pkg.sv ***
// sad_pkg: address map constants and result encodings for the system address decoder
// assumes: a 41-bit cpu physical address and a 32-bit pci address
package sad_pkg;

  // ****************************************
  // cpu physical space
  // ****************************************
  localparam int          CPU_AW             = 41;
  localparam logic [40:0] MEM_TOP            = 41'h000_3FFF_FFFF;
  localparam logic [40:0] GFX_BASE           = 41'h1FC_0000_0000;
  localparam logic [40:0] GFX_TOP            = 41'h1FD_FFFF_FFFF;
  localparam logic [40:0] CPUIO_BASE         = 41'h1FE_0000_0000;
  localparam logic [40:0] TRAP_CPU_ADDR      = 41'h1FF_F000_0000;

  // ****************************************
  // pci space
  // ****************************************
  localparam logic [31:0] DEV_DMA_BASE       = 32'h8000_0000;
  localparam logic [31:0] DEV_DMA_TOP        = 32'hBFFF_FFFF;
  localparam logic [7:0]  DEV_DMA_SETTING    = 8'h30;
  localparam logic [31:0] SLOT_MEM_BASE      = 32'h4000_0000;
  localparam logic [31:0] SLOT_MEM_TOP       = 32'h7FFF_FFFF;
  localparam logic [7:0]  SLOT_SETTING       = 8'h0C;
  localparam logic [31:0] SLOT_IO_BASE       = 32'h0040_0000;
  localparam logic [31:0] SLOT_IO_TOP        = 32'h007F_FFFF;
  localparam logic [31:0] ONB_MEM_LO_TOP     = 32'h3FFF_FFFF;
  localparam logic [31:0] ONB_MEM_HI_BASE    = 32'hC000_0000;
  localparam logic [7:0]  ONB_SETTING        = 8'hC3;
  localparam logic [31:0] ONB_IO_LO_TOP      = 32'h003F_FFFF;
  localparam logic [31:0] ONB_IO_HI_BASE     = 32'h00C0_0000;
  localparam logic [31:0] ONB_IO_HI_TOP      = 32'h00FF_FFFF;
  localparam logic [31:0] TRAP_PCI_ADDR      = 32'hF000_0000;
  localparam logic [23:0] ROM_TOP            = 24'hFF_FFFF;
  localparam logic [23:0] TRAP_EXP_OFFSET    = 24'h00_0000;

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [2:0] {
    SAD_CPU_NONE  = 3'b000,
    SAD_CPU_MEM   = 3'b001,
    SAD_CPU_GFX   = 3'b010,
    SAD_CPU_IO    = 3'b011
  } sad_cpu_port_t;

  typedef enum logic [2:0] {
    SAD_PCI_NONE  = 3'b000,
    SAD_PCI_DMA   = 3'b001,
    SAD_PCI_SLOT  = 3'b010,
    SAD_PCI_ONB   = 3'b011
  } sad_pci_port_t;

  // three companion base pointers: boot rom, expansion bus fn 0, network fn 1
  typedef enum logic [1:0] {
    SAD_BAR_ROM   = 2'b00,
    SAD_BAR_EXP   = 2'b01,
    SAD_BAR_NET   = 2'b10
  } sad_bar_t;
  localparam int NUM_BARS = 3;

  typedef enum logic [1:0] {
    SAD_ST_RESET  = 2'b00,
    SAD_ST_BOOT   = 2'b01,
    SAD_ST_LOCKED = 2'b10
  } sad_state_t;

endpackage

// *** tb/sad_decoder_sva.sv ***
// sad_decoder_sva: port-level checks of the address decoder
// assumes: bound to sad_decoder, one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none
module sad_decoder_sva
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        reset_i,
  // requests
  input wire logic        cpu_req_i,
  input wire logic [40:0] cpu_addr_i,
  input wire logic        pci_req_i,
  input wire logic        pci_io_i,
  input wire logic [31:0] pci_addr_i,
  input wire logic        bridge_fitted_i,
  input wire logic        boot_done_i,
  // decisions
  input wire logic        cpu_valid_o,
  input wire logic [2:0]  cpu_port_o,
  input wire logic        cpu_cacheable_o,
  input wire logic        cpu_trap_o,
  input wire logic [2:0]  pci_port_o,
  input wire logic [7:0]  pci_setting_o,
  input wire logic        rom_hit_o,
  input wire logic        rom_err_o,
  input wire logic        boot_open_o
);
  // ****************************************
  // properties
  // ****************************************
  // every decision lands one edge after its request; boot_open_o drops two edges after boot_done_i
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic mem_in;
  logic pm;
  assign mem_in = pci_req_i && !pci_io_i;
  assign pm = mem_in && bridge_fitted_i;
  property p_mem;
    cpu_req_i && cpu_addr_i <= 41'h000_3FFF_FFFF |=> cpu_valid_o && cpu_port_o == 3'h1 && cpu_cacheable_o;
  endproperty
  a_mem: assert property (p_mem) else $error("low memory not routed cacheable");
  property p_gfx;
    cpu_req_i && cpu_addr_i[40:33] == 8'hFE |=> cpu_port_o == 3'h2 && !cpu_cacheable_o;
  endproperty
  a_gfx: assert property (p_gfx) else $error("graphics window misrouted");
  property p_cio;
    cpu_req_i && cpu_addr_i[40:33] == 8'hFF |=> cpu_port_o == 3'h3 && !cpu_cacheable_o;
  endproperty
  a_cio: assert property (p_cio) else $error("cpu io window misrouted");
  property p_unused;
    cpu_req_i && cpu_addr_i > 41'h000_3FFF_FFFF && cpu_addr_i[40:34] != 7'h7F |=> cpu_valid_o && cpu_port_o == 3'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused range forwarded");
  property p_trap;
    cpu_req_i |=> cpu_trap_o == ($past(cpu_addr_i) == 41'h1FF_F000_0000);
  endproperty
  a_trap: assert property (p_trap) else $error("trap flag wrong");
  property p_dma;
    mem_in && pci_addr_i[31:30] == 2'h2 |=> pci_port_o == 3'h1 && pci_setting_o == 8'h30;
  endproperty
  a_dma: assert property (p_dma) else $error("dma window misrouted");
  property p_slot;
    pm && pci_addr_i[31:30] == 2'h1 |=> pci_port_o == 3'h2 && pci_setting_o == 8'h0C;
  endproperty
  a_slot: assert property (p_slot) else $error("slot memory misrouted");
  property p_onb;
    pm && (pci_addr_i[31:30] == 2'h0 || pci_addr_i[31:30] == 2'h3) |=> pci_port_o == 3'h3 && pci_setting_o == 8'hC3;
  endproperty
  a_onb: assert property (p_onb) else $error("onboard memory misrouted");
  property p_romerr;
    rom_err_o |-> rom_hit_o;
  endproperty
  a_romerr: assert property (p_romerr) else $error("rom error without hit");
  property p_lock;
    boot_done_i |=> ##1 !boot_open_o [*3];
  endproperty
  a_lock: assert property (p_lock) else $error("relocation still open");
  c_gfx: cover property (cpu_port_o == 3'h2);
  c_dma: cover property (pci_port_o == 3'h1);
  c_rom: cover property (rom_hit_o && !rom_err_o);
endmodule
bind sad_decoder sad_decoder_sva u_sva (.clk_i, .reset_i, .cpu_req_i, .cpu_addr_i, .pci_req_i, .pci_io_i,
  .pci_addr_i, .bridge_fitted_i, .boot_done_i, .cpu_valid_o, .cpu_port_o, .cpu_cacheable_o, .cpu_trap_o,
  .pci_port_o, .pci_setting_o, .rom_hit_o, .rom_err_o, .boot_open_o);
`default_nettype wire

// *** tb/sad_req_model.sv ***
// sad_req_model: cpu module and pci client requests with boot firmware writes
// assumes: all changes made by non-blocking assignment at the rising edge
`timescale 1ns/1ns
`default_nettype none
module sad_req_model
(
  // clock
  input  wire logic        clk_i,
  // requests
  output logic             cpu_req_o = 1'b0,
  output logic [40:0]      cpu_addr_o = 41'h0,
  output logic             pci_req_o = 1'b0,
  output logic             pci_io_o = 1'b0,
  output logic [31:0]      pci_addr_o = 32'h0,
  output logic             pci_write_o = 1'b0,
  output logic [2:0]       pci_size_o = 3'h4,
  // boot control
  output logic             bridge_o = 1'b1,
  output logic             boot_done_o = 1'b0,
  output logic             bar_wr_o = 1'b0,
  output logic [1:0]       bar_sel_o = 2'h0,
  output logic [31:0]      bar_wdata_o = 32'h0
);
  // ****************************************
  // request tasks
  // ****************************************
  // each returns on the edge that samples its request
  task automatic cpu(input logic [40:0] a);
    @(posedge clk_i);
    cpu_req_o <= 1'b1;
    cpu_addr_o <= a;
    @(posedge clk_i);
  endtask
  task automatic pci(input logic io, input logic [31:0] a, input logic wr, input logic [2:0] sz);
    @(posedge clk_i);
    pci_req_o <= 1'b1;
    pci_io_o <= io;
    pci_addr_o <= a;
    pci_write_o <= wr;
    pci_size_o <= sz;
    @(posedge clk_i);
  endtask
  // firmware pointer write; the base file accepts it only while boot is open
  task automatic bar(input logic [1:0] s, input logic [31:0] d);
    @(posedge clk_i);
    bar_wr_o <= 1'b1;
    bar_sel_o <= s;
    bar_wdata_o <= d;
    @(posedge clk_i);
    bar_wr_o <= 1'b0;
  endtask
  task automatic done();
    @(posedge clk_i);
    boot_done_o <= 1'b1;
    @(posedge clk_i);
    boot_done_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// tb: directed tests of the address decoder
// assumes: sad_req_model drives every request input
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ****************************************
  // harness
  // ****************************************
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  int n_mismatch = 0;
  int check_count = 0;
  wire logic cr, pr, pio, pw, br, bd, bw, cv, cc, ct, pv, rh, re, eh, nh, bo;
  wire logic [40:0] ca;
  wire logic [31:0] pa, bwd, rb;
  wire logic [2:0] psz, cp, pp;
  wire logic [1:0] bs;
  wire logic [7:0] ps;
  wire logic [23:0] ro;
  always #50 clk_i = ~clk_i;
  sad_req_model u_model (.clk_i(clk_i), .cpu_req_o(cr), .cpu_addr_o(ca), .pci_req_o(pr), .pci_io_o(pio),
    .pci_addr_o(pa), .pci_write_o(pw), .pci_size_o(psz), .bridge_o(br), .boot_done_o(bd), .bar_wr_o(bw),
    .bar_sel_o(bs), .bar_wdata_o(bwd));
  sad_decoder u_dut (.clk_i(clk_i), .reset_i(reset_i), .cpu_req_i(cr), .cpu_addr_i(ca), .pci_req_i(pr),
    .pci_io_i(pio), .pci_addr_i(pa), .pci_write_i(pw), .pci_size_i(psz), .bridge_fitted_i(br),
    .boot_done_i(bd), .bar_wr_i(bw), .bar_sel_i(bs), .bar_wdata_i(bwd), .cpu_valid_o(cv), .cpu_port_o(cp),
    .cpu_cacheable_o(cc), .cpu_trap_o(ct), .pci_valid_o(pv), .pci_port_o(pp), .pci_setting_o(ps),
    .rom_hit_o(rh), .rom_err_o(re), .rom_offset_o(ro), .exp_hit_o(eh), .net_hit_o(nh), .boot_open_o(bo),
    .rom_base_o(rb));
  task automatic chk(input string nm, input logic [40:0] seen, input logic [40:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tcpu(input logic [40:0] a, input logic [2:0] p, input logic c, input logic t);
    u_model.cpu(a);
    @(negedge clk_i);
    chk("cpu_port", 41'({cv, cp, cc, ct}), 41'({1'b1, p, c, t}));
  endtask
  task automatic tpci(input logic io, input logic [31:0] a, input logic [2:0] p, input logic [7:0] s);
    u_model.pci(io, a, 1'b0, 3'h4);
    @(negedge clk_i);
    chk("pci_port", 41'({pv, pp, ps}), 41'({1'b1, p, s}));
  endtask
  task automatic trom(input logic [31:0] a, input logic w, input logic [2:0] z, input logic h, input logic e,
                      input logic [23:0] o);
    u_model.pci(1'b0, a, w, z);
    @(negedge clk_i);
    chk("rom", 41'({rh, re, ro}), 41'({h, e, o}));
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    @(negedge clk_i);
    chk("rom_base", 41'(rb), 41'hF000_0000);
    chk("boot_open", 41'(bo), 41'h0);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("boot_open", 41'(bo), 41'h1);
    $display("test reset done");
  endtask
  task automatic t_cpu();
    tcpu(41'h000_0000_0000, 3'h1, 1'b1, 1'b0);
    tcpu(41'h000_3FFF_FFFF, 3'h1, 1'b1, 1'b0);
    tcpu(41'h000_4000_0000, 3'h0, 1'b0, 1'b0);
    tcpu(41'h1FB_FFFF_FFFF, 3'h0, 1'b0, 1'b0);
    tcpu(41'h1FC_0000_0000, 3'h2, 1'b0, 1'b0);
    tcpu(41'h1FD_FFFF_FFFF, 3'h2, 1'b0, 1'b0);
    tcpu(41'h1FE_0000_0000, 3'h3, 1'b0, 1'b0);
    tcpu(41'h1FF_F000_0000, 3'h3, 1'b0, 1'b1);
    $display("test cpu done");
  endtask
  task automatic t_pci();
    tpci(1'b0, 32'h8000_0000, 3'h1, 8'h30);
    tpci(1'b0, 32'hBFFF_FFFF, 3'h1, 8'h30);
    tpci(1'b0, 32'h4000_0000, 3'h2, 8'h0C);
    tpci(1'b0, 32'h7FFF_FFFF, 3'h2, 8'h0C);
    tpci(1'b0, 32'h3FFF_FFFF, 3'h3, 8'hC3);
    tpci(1'b0, 32'hC000_0000, 3'h3, 8'hC3);
    tpci(1'b1, 32'h0040_0000, 3'h2, 8'h00);
    tpci(1'b1, 32'h007F_FFFF, 3'h2, 8'h00);
    tpci(1'b1, 32'h003F_FFFF, 3'h3, 8'h00);
    tpci(1'b1, 32'h00C0_0000, 3'h3, 8'h00);
    tpci(1'b1, 32'h0080_0000, 3'h0, 8'h00);
    @(posedge clk_i) u_model.bridge_o <= 1'b0;
    tpci(1'b0, 32'h0000_0000, 3'h2, 8'h0C);
    tpci(1'b1, 32'h00C0_0000, 3'h2, 8'h00);
    @(posedge clk_i) u_model.bridge_o <= 1'b1;
    $display("test pci done");
  endtask
  task automatic t_rom();
    trom(32'hF000_0000, 1'b0, 3'h4, 1'b1, 1'b0, 24'h00_0000);
    trom(32'hF0FF_FFFF, 1'b0, 3'h1, 1'b1, 1'b0, 24'hFF_FFFF);
    trom(32'hF000_0010, 1'b0, 3'h2, 1'b1, 1'b1, 24'h00_0010);
    trom(32'hF000_0000, 1'b1, 3'h4, 1'b1, 1'b1, 24'h00_0000);
    trom(32'hF100_0000, 1'b0, 3'h4, 1'b0, 1'b0, 24'h00_0000);
    $display("test rom done");
  endtask
  // relocation while open, then refused once boot closes
  task automatic t_bar();
    u_model.bar(2'h1, 32'h1000_0000);
    u_model.bar(2'h2, 32'h2000_0000);
    u_model.bar(2'h0, 32'h3000_0000);
    u_model.bar(2'h3, 32'h2000_0000);
    u_model.pci(1'b0, 32'h1000_0004, 1'b0, 3'h4);
    @(negedge clk_i);
    chk("exp_net", 41'({eh, nh}), 41'h2);
    u_model.pci(1'b0, 32'h2000_0000, 1'b0, 3'h4);
    @(negedge clk_i);
    chk("exp_net", 41'({eh, nh}), 41'h1);
    chk("rom_base", 41'(rb), 41'h3000_0000);
    trom(32'h3000_0004, 1'b0, 3'h4, 1'b1, 1'b0, 24'h00_0004);
    u_model.done();
    u_model.bar(2'h0, 32'h5000_0000);
    trom(32'h5000_0000, 1'b0, 3'h4, 1'b0, 1'b0, 24'h00_0000);
    chk("rom_base", 41'({bo, rb}), 41'h3000_0000);
    $display("test bar done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog: tests need some 90 cycles, allow far more
  initial
  begin
    #500000;
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_cpu();
    t_pci();
    t_rom();
    t_bar();
    // second reset must restore the trap pointer and reopen relocation
    @(posedge clk_i) reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    trom(32'hF000_0000, 1'b0, 3'h1, 1'b1, 1'b0, 24'h00_0000);
    end_sim();
  end
endmodule
`default_nettype wire
